// file: upi_cfg.svh
// Constants for the user panel I/O block: widths, segment positions, resets, timing
`ifndef UPI_CFG_SVH
`define UPI_CFG_SVH

// Panel population
`define UPI_NUM_KEYS        4
`define UPI_NUM_SW          10
`define UPI_NUM_LED         10
`define UPI_NUM_DIGITS      6
`define UPI_NUM_BCLK        3
`define UPI_SEG_W           7
`define UPI_VAL_W           4

// Segment bit positions inside one digit vector
`define UPI_SEG_TOP         0
`define UPI_SEG_UR          1
`define UPI_SEG_LR          2
`define UPI_SEG_BOT         3
`define UPI_SEG_LL          4
`define UPI_SEG_UL          5
`define UPI_SEG_MID         6

// Reset and drive values
`define UPI_SEG_OFF         7'h7F
`define UPI_SEG_ALL_ON      7'h00
`define UPI_LED_RST         10'h000
`define UPI_KEY_SYNC_RST    4'hF

// Timing: core clock period and board clock watchdog window
`define UPI_CLK_PERIOD_NS   5
`define UPI_BCLK_FREQ_MHZ   50
`define UPI_ALIVE_WIN_NS    1000
`define UPI_ALIVE_CYCLES    (`UPI_ALIVE_WIN_NS / `UPI_CLK_PERIOD_NS)

`endif

// file: upi_pkg.sv
// Types shared by the user panel I/O block
`include "upi_cfg.svh"

package upi_pkg;

    // One displayed digit as the user logic supplies it
    typedef struct packed {
        logic                   blank;   // High blanks the digit
        logic [`UPI_VAL_W-1:0]  value;   // Hex value to show
    } upi_digit_s;

    // All six digits, digit 0 in the low slot
    typedef upi_digit_s [`UPI_NUM_DIGITS-1:0] upi_digit_t;

    // Segment vector, index 0 to 6, active low
    typedef logic [`UPI_SEG_W-1:0] upi_seg_t;

    // Conditioned push-button state, active high
    typedef struct packed {
        logic [`UPI_NUM_KEYS-1:0] held;  // Button is down
        logic [`UPI_NUM_KEYS-1:0] press; // One-cycle pulse on press
        logic [`UPI_NUM_KEYS-1:0] rel;   // One-cycle pulse on release
    } upi_key_s;

endpackage

// file: upi_seg_decode.sv
// Hex value to active-low seven-segment pattern decoder
`timescale 1ns/100ps
`default_nettype none
`include "upi_cfg.svh"

module upi_seg_decode (
    input  wire logic                  blank,
    input  wire logic [`UPI_VAL_W-1:0] value,
    output upi_pkg::upi_seg_t          seg_n
);
    import upi_pkg::*;

    upi_seg_t seg_on;  // Active-high pattern, bit 0 top .. bit 6 middle

    // Conventional hex glyphs, then inverted for the common anode
    always_comb begin
        case (value)
            4'h0:    seg_on = 7'h3F;
            4'h1:    seg_on = 7'h06;
            4'h2:    seg_on = 7'h5B;
            4'h3:    seg_on = 7'h4F;
            4'h4:    seg_on = 7'h66;
            4'h5:    seg_on = 7'h6D;
            4'h6:    seg_on = 7'h7D;
            4'h7:    seg_on = 7'h07;
            4'h8:    seg_on = 7'h7F;
            4'h9:    seg_on = 7'h6F;
            4'hA:    seg_on = 7'h77;
            4'hB:    seg_on = 7'h7C;
            4'hC:    seg_on = 7'h39;
            4'hD:    seg_on = 7'h5E;
            4'hE:    seg_on = 7'h79;
            4'hF:    seg_on = 7'h71;
            default: seg_on = 7'h00;
        endcase
        // Blank forces every segment high, that is dark
        if (blank) begin
            seg_n = `UPI_SEG_OFF;
        end else begin
            seg_n = ~seg_on; // [R6] [R11]
        end
    end

endmodule
`default_nettype wire

// file: upi_panel.sv
// Front-panel user I/O: buttons, switches, LEDs, six seven-segment digits
//
// Contract
// [R1] Button pin high released, low pressed
// [R2] Buttons arrive debounced, no filter needed
// [R3] Switches are bouncing level data only
// [R4] Switch low when down, high when up
// [R5] LED line high lights, low extinguishes
// [R6] Segment line low lights, high darkens
// [R7] Seven-bit segment vector, indices 0..6
// [R8] Six digit outputs in three pairs
// [R9] Four 50 MHz board clocks feed logic; this block takes only three, BOARD_CLK_B to BOARD_CLK_D
// [R10] Two-flop synchronise switches and buttons
// [R11] Decoder maps indices to conventional segments
`timescale 1ns/100ps
`default_nettype none
`include "upi_cfg.svh"

module upi_panel #(
    parameter int NUM_SW       = `UPI_NUM_SW,       // Slide switch count
    parameter int NUM_LED      = `UPI_NUM_LED,      // LED count
    parameter int ALIVE_CYCLES = `UPI_ALIVE_CYCLES  // Board clock watchdog window
) (
    input  wire logic                      CORE_CLK,
    input  wire logic                      RESET,
    input  wire logic [`UPI_NUM_KEYS-1:0]  KEY_PIN_N,
    input  wire logic [NUM_SW-1:0]         SLIDE_SWITCH_IN,
    input  wire logic                      BOARD_CLK_B,
    input  wire logic                      BOARD_CLK_C,
    input  wire logic                      BOARD_CLK_D,
    input  wire logic [NUM_LED-1:0]        LED_VALUE,
    input  wire upi_pkg::upi_digit_t       DIGIT_IN,
    input  wire logic                      LAMP_TEST,
    output var  upi_pkg::upi_key_s         KEY_STATUS,
    output logic [NUM_SW-1:0]              SWITCH_LEVEL,
    output logic [`UPI_NUM_BCLK-1:0]       BOARD_CLK_ALIVE,
    output logic [NUM_LED-1:0]             RED_LED_OUT,
    output upi_pkg::upi_seg_t              SEGMENT_DIGIT_0,
    output upi_pkg::upi_seg_t              SEGMENT_DIGIT_1,
    output upi_pkg::upi_seg_t              SEGMENT_DIGIT_2,
    output upi_pkg::upi_seg_t              SEGMENT_DIGIT_3,
    output upi_pkg::upi_seg_t              SEGMENT_DIGIT_4,
    output upi_pkg::upi_seg_t              SEGMENT_DIGIT_5
);
    import upi_pkg::*;

    // Watchdog counter width and saturation value
    localparam int                 ALIVE_W   = $clog2(ALIVE_CYCLES + 1);
    localparam logic [ALIVE_W-1:0] ALIVE_MAX = ALIVE_W'(ALIVE_CYCLES);

    // ------------------------------------------------------------------
    // Push-buttons
    // ------------------------------------------------------------------
    logic [`UPI_NUM_KEYS-1:0] key_s1_r;    // Synchroniser stage 1
    logic [`UPI_NUM_KEYS-1:0] key_s2_r;    // Synchroniser stage 2
    logic [`UPI_NUM_KEYS-1:0] key_s1_nxt;  // Next stage 1
    logic [`UPI_NUM_KEYS-1:0] key_s2_nxt;  // Next stage 2
    upi_key_s                 key_r;       // Conditioned key state
    upi_key_s                 key_nxt;     // Next key state

    // Buttons are already clean, so only the crossing and edge finding remain
    always_comb begin
        key_s1_nxt    = KEY_PIN_N;                          // [R10] [R2]
        key_s2_nxt    = key_s1_r;                           // [R10]
        key_nxt.held  = ~key_s2_r;                          // [R1]
        key_nxt.press = ~key_s2_r & ~key_r.held;            // [R1]
        key_nxt.rel   = key_s2_r & key_r.held;
    end

    // Key registers; pins reset as released
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            key_s1_r <= `UPI_KEY_SYNC_RST;
            key_s2_r <= `UPI_KEY_SYNC_RST;
            key_r    <= '0;
        end else begin
            key_s1_r <= key_s1_nxt;
            key_s2_r <= key_s2_nxt;
            key_r    <= key_nxt;
        end
    end

    assign KEY_STATUS = key_r;

    // ------------------------------------------------------------------
    // Slide switches
    // ------------------------------------------------------------------
    logic [NUM_SW-1:0] sw_s1_r;    // Synchroniser stage 1
    logic [NUM_SW-1:0] sw_s2_r;    // Synchroniser stage 2, the clean level
    logic [NUM_SW-1:0] sw_s1_nxt;  // Next stage 1
    logic [NUM_SW-1:0] sw_s2_nxt;  // Next stage 2

    // Levels pass unchanged: low means down, high means up
    always_comb begin
        sw_s1_nxt = SLIDE_SWITCH_IN;  // [R10] [R4]
        sw_s2_nxt = sw_s1_r;          // [R10]
    end

    // Switch synchroniser registers
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            sw_s1_r <= '0;
            sw_s2_r <= '0;
        end else begin
            sw_s1_r <= sw_s1_nxt;
            sw_s2_r <= sw_s2_nxt;
        end
    end

    // Bouncing shows through as a level; no edge is derived here
    assign SWITCH_LEVEL = sw_s2_r; // [R3]

    // ------------------------------------------------------------------
    // Board clock watchdog, one lane per spare 50 MHz clock
    // ------------------------------------------------------------------
    logic [`UPI_NUM_BCLK-1:0] bclk_pin;    // Raw board clock pins
    logic [`UPI_NUM_BCLK-1:0] bclk_s1_r;   // Synchroniser stage 1
    logic [`UPI_NUM_BCLK-1:0] bclk_s2_r;   // Synchroniser stage 2
    logic [`UPI_NUM_BCLK-1:0] bclk_s3_r;   // Delayed copy for edge detect
    logic [`UPI_NUM_BCLK-1:0] alive_r;     // Clock seen toggling recently
    logic [ALIVE_W-1:0]       cnt_r [`UPI_NUM_BCLK]; // Cycles since last edge

    assign bclk_pin = {BOARD_CLK_D, BOARD_CLK_C, BOARD_CLK_B};

    genvar g;
    generate
        for (g = 0; g < `UPI_NUM_BCLK; g++) begin : g_bclk
            logic               s1_nxt;     // Next stage 1
            logic               s2_nxt;     // Next stage 2
            logic               s3_nxt;     // Next delayed copy
            logic               alive_nxt;  // Next alive flag
            logic [ALIVE_W-1:0] cnt_nxt;    // Next counter

            // Restart the window on any edge, saturate when none arrives
            always_comb begin
                s1_nxt = bclk_pin[g];
                s2_nxt = bclk_s1_r[g];
                s3_nxt = bclk_s2_r[g];
                if (bclk_s2_r[g] != bclk_s3_r[g]) begin
                    cnt_nxt = '0;                              // [R9]
                end else if (cnt_r[g] == ALIVE_MAX) begin
                    cnt_nxt = cnt_r[g];
                end else begin
                    cnt_nxt = cnt_r[g] + ALIVE_W'(1);
                end
                alive_nxt = (cnt_nxt != ALIVE_MAX);            // [R9]
            end

            // Watchdog registers; a lane reads dead until edges appear
            always_ff @(posedge CORE_CLK) begin
                if (RESET) begin
                    bclk_s1_r[g] <= 1'b0;
                    bclk_s2_r[g] <= 1'b0;
                    bclk_s3_r[g] <= 1'b0;
                    cnt_r[g]     <= ALIVE_MAX;
                    alive_r[g]   <= 1'b0;
                end else begin
                    bclk_s1_r[g] <= s1_nxt;
                    bclk_s2_r[g] <= s2_nxt;
                    bclk_s3_r[g] <= s3_nxt;
                    cnt_r[g]     <= cnt_nxt;
                    alive_r[g]   <= alive_nxt;
                end
            end
        end
    endgenerate

    assign BOARD_CLK_ALIVE = alive_r;

    // ------------------------------------------------------------------
    // LEDs
    // ------------------------------------------------------------------
    logic [NUM_LED-1:0] led_r;    // Registered LED drive
    logic [NUM_LED-1:0] led_nxt;  // Next LED drive

    // Each line independent; high lights, lamp test lights all
    always_comb begin
        if (LAMP_TEST) begin
            led_nxt = '1;          // [R5]
        end else begin
            led_nxt = LED_VALUE;   // [R5]
        end
    end

    // LED register, dark after reset
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            led_r <= NUM_LED'(`UPI_LED_RST);
        end else begin
            led_r <= led_nxt;
        end
    end

    assign RED_LED_OUT = led_r;

    // ------------------------------------------------------------------
    // Seven-segment digits
    // ------------------------------------------------------------------
    upi_seg_t seg_dec [`UPI_NUM_DIGITS];  // Decoder outputs, active low
    upi_seg_t seg_nxt [`UPI_NUM_DIGITS];  // Next segment drive
    upi_seg_t seg_r   [`UPI_NUM_DIGITS];  // Registered segment drive

    genvar d;
    generate
        for (d = 0; d < `UPI_NUM_DIGITS; d++) begin : g_digit
            // Per-digit glyph decode
            upi_seg_decode u_dec (
                .blank (DIGIT_IN[d].blank),
                .value (DIGIT_IN[d].value),
                .seg_n (seg_dec[d])
            ); // [R11]

            // Lamp test pulls every segment low, which lights it
            always_comb begin
                if (LAMP_TEST) begin
                    seg_nxt[d] = `UPI_SEG_ALL_ON;   // [R6]
                end else begin
                    seg_nxt[d] = seg_dec[d];        // [R7]
                end
            end

            // Segment register, all dark after reset
            always_ff @(posedge CORE_CLK) begin
                if (RESET) begin
                    seg_r[d] <= `UPI_SEG_OFF;       // [R6]
                end else begin
                    seg_r[d] <= seg_nxt[d];
                end
            end
        end
    endgenerate

    // Three adjacent pairs: 1:0, 3:2, 5:4
    assign SEGMENT_DIGIT_0 = seg_r[0]; // [R8]
    assign SEGMENT_DIGIT_1 = seg_r[1];
    assign SEGMENT_DIGIT_2 = seg_r[2];
    assign SEGMENT_DIGIT_3 = seg_r[3];
    assign SEGMENT_DIGIT_4 = seg_r[4];
    assign SEGMENT_DIGIT_5 = seg_r[5];

endmodule
`default_nettype wire

// file: upi_panel_chk.sv
// Checker for the user panel I/O block
`timescale 1ns/100ps
`default_nettype none
`include "upi_cfg.svh"
module upi_panel_chk #(
    parameter int NUM_SW       = `UPI_NUM_SW,
    parameter int NUM_LED      = `UPI_NUM_LED,
    parameter int ALIVE_CYCLES = `UPI_ALIVE_CYCLES
) (
    input wire logic                     CORE_CLK,
    input wire logic                     RESET,
    input wire logic [`UPI_NUM_KEYS-1:0] KEY_PIN_N,
    input wire logic [NUM_SW-1:0]        SLIDE_SWITCH_IN,
    input wire logic                     BOARD_CLK_B,
    input wire logic                     BOARD_CLK_C,
    input wire logic                     BOARD_CLK_D,
    input wire logic [NUM_LED-1:0]       LED_VALUE,
    input wire upi_pkg::upi_digit_t      DIGIT_IN,
    input wire logic                     LAMP_TEST,
    input wire upi_pkg::upi_key_s        KEY_STATUS,
    input wire logic [NUM_SW-1:0]        SWITCH_LEVEL,
    input wire logic [`UPI_NUM_BCLK-1:0] BOARD_CLK_ALIVE,
    input wire logic [NUM_LED-1:0]       RED_LED_OUT,
    input wire upi_pkg::upi_seg_t        SEGMENT_DIGIT_0,
    input wire upi_pkg::upi_seg_t        SEGMENT_DIGIT_1,
    input wire upi_pkg::upi_seg_t        SEGMENT_DIGIT_2,
    input wire upi_pkg::upi_seg_t        SEGMENT_DIGIT_3,
    input wire upi_pkg::upi_seg_t        SEGMENT_DIGIT_4,
    input wire upi_pkg::upi_seg_t        SEGMENT_DIGIT_5
);
    import upi_pkg::*;
    logic [2:0] rdy_r;   // Edges since reset, saturating
    logic [2:0] rdy_nxt; // Next count
    wire logic  ready;   // Synchronisers hold post-reset history
    // Count up to four edges after reset
    always_comb begin
        rdy_nxt = (rdy_r == 3'h4) ? rdy_r : rdy_r + 3'h1;
    end
    // Register the count
    always_ff @(posedge CORE_CLK) begin
        rdy_r <= RESET ? 3'h0 : rdy_nxt;
    end
    assign ready = (rdy_r == 3'h4);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    // Button 0 goes down, then its press pulse
    sequence key0_down; ready && $fell(KEY_PIN_N[0]); endsequence
    sequence press0_pulse; KEY_STATUS.press[0] ##1 !KEY_STATUS.press[0]; endsequence
    chk_press_one_pulse: assert property (key0_down |-> ##3 press0_pulse)
        else $error("press pulse wrong");
    chk_key_held_sync: assert property (ready |-> KEY_STATUS.held == ~$past(KEY_PIN_N, 3))
        else $error("held level wrong");
    chk_switch_two_flop: assert property (ready |-> SWITCH_LEVEL == $past(SLIDE_SWITCH_IN, 2))
        else $error("switch level wrong");
    chk_led_follow: assert property (!LAMP_TEST |=> RED_LED_OUT == $past(LED_VALUE))
        else $error("led drive wrong");
    chk_lamp_all_on: assert property (LAMP_TEST |=> &RED_LED_OUT && SEGMENT_DIGIT_5 == 7'h00)
        else $error("lamp test wrong");
    chk_blank_dark: assert property (!LAMP_TEST && DIGIT_IN[0].blank |=> SEGMENT_DIGIT_0 == 7'h7F)
        else $error("blank digit lit");
    chk_glyph_eight: assert property (!LAMP_TEST && DIGIT_IN[1] == 5'h08 |=> SEGMENT_DIGIT_1 == 7'h00)
        else $error("glyph eight wrong");
    chk_glyph_one: assert property (!LAMP_TEST && DIGIT_IN[4] == 5'h01 |=> SEGMENT_DIGIT_4 == 7'h79)
        else $error("glyph one wrong");
    chk_clk_alive: assert property (ready && $changed(BOARD_CLK_B) |-> ##[1:4] BOARD_CLK_ALIVE[0])
        else $error("board clock not seen");
endmodule
bind upi_panel upi_panel_chk #(.NUM_SW(NUM_SW), .NUM_LED(NUM_LED), .ALIVE_CYCLES(ALIVE_CYCLES))
    u_chk (.CORE_CLK(CORE_CLK), .RESET(RESET), .KEY_PIN_N(KEY_PIN_N),
    .SLIDE_SWITCH_IN(SLIDE_SWITCH_IN), .BOARD_CLK_B(BOARD_CLK_B), .BOARD_CLK_C(BOARD_CLK_C),
    .BOARD_CLK_D(BOARD_CLK_D), .LED_VALUE(LED_VALUE), .DIGIT_IN(DIGIT_IN), .LAMP_TEST(LAMP_TEST),
    .KEY_STATUS(KEY_STATUS), .SWITCH_LEVEL(SWITCH_LEVEL), .BOARD_CLK_ALIVE(BOARD_CLK_ALIVE),
    .RED_LED_OUT(RED_LED_OUT), .SEGMENT_DIGIT_0(SEGMENT_DIGIT_0), .SEGMENT_DIGIT_1(SEGMENT_DIGIT_1),
    .SEGMENT_DIGIT_2(SEGMENT_DIGIT_2), .SEGMENT_DIGIT_3(SEGMENT_DIGIT_3),
    .SEGMENT_DIGIT_4(SEGMENT_DIGIT_4), .SEGMENT_DIGIT_5(SEGMENT_DIGIT_5));
`default_nettype wire

// file: upi_panel_board.sv
// Board model: buttons, bouncing slide switches, spare 50 MHz clocks
`timescale 1ns/100ps
`default_nettype none
module upi_panel_board (
    input wire logic [3:0] key_down,
    input wire logic [9:0] sw_up,
    input wire logic [2:0] clk_run,
    output logic     [3:0] key_pin_n,
    output logic     [9:0] sw_pin,
    output logic     [2:0] bclk
);
    // Debounced buttons, low while held
    assign key_pin_n = ~key_down;
    // Switch moves bounce briefly, then settle
    initial begin
        sw_pin = sw_up;
        forever begin
            @(sw_up);
            sw_pin = ~sw_up;
            #1 sw_pin = sw_up;
            #0.5 sw_pin = ~sw_up;
            #0.5 sw_pin = sw_up;
        end
    end
    // Each clock toggles every 10 ns while running, else stands
    for (genvar i = 0; i < 3; i++) begin : g_clk
        logic c;
        initial begin
            c = 1'b0;
            forever #10 if (clk_run[i]) c = ~c;
        end
        assign bclk[i] = c;
    end
endmodule
`default_nettype wire

// file: upi_panel_tb_top.sv
// Self-checking testbench for the user panel I/O block
`timescale 1ns/100ps
`default_nettype none
module upi_panel_tb_top;
    import upi_pkg::*;
    localparam int ALIVE_N = 8; // Short watchdog window
    localparam logic [6:0] GLY [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
        7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
    logic clk, rst, lamp;
    logic [3:0] key_dn, key_n;
    logic [9:0] sw_up, sw_pin, led_v, sw_lvl, led_o;
    logic [2:0] run, bclk, alive;
    upi_digit_t dig;
    upi_key_s ks;
    upi_seg_t seg [6];
    int failures, samples_checked, cyc;
    upi_panel_board u_board (.key_down(key_dn), .sw_up(sw_up), .clk_run(run),
        .key_pin_n(key_n), .sw_pin(sw_pin), .bclk(bclk));
    upi_panel #(.ALIVE_CYCLES(ALIVE_N)) u_dut (.CORE_CLK(clk), .RESET(rst), .KEY_PIN_N(key_n),
        .SLIDE_SWITCH_IN(sw_pin), .BOARD_CLK_B(bclk[0]), .BOARD_CLK_C(bclk[1]),
        .BOARD_CLK_D(bclk[2]), .LED_VALUE(led_v), .DIGIT_IN(dig), .LAMP_TEST(lamp),
        .KEY_STATUS(ks), .SWITCH_LEVEL(sw_lvl), .BOARD_CLK_ALIVE(alive), .RED_LED_OUT(led_o),
        .SEGMENT_DIGIT_0(seg[0]), .SEGMENT_DIGIT_1(seg[1]), .SEGMENT_DIGIT_2(seg[2]),
        .SEGMENT_DIGIT_3(seg[3]), .SEGMENT_DIGIT_4(seg[4]), .SEGMENT_DIGIT_5(seg[5]));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Compare one value and count it
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Let n rising edges land
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Press and release each button, exact latency
    task automatic t_keys;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk) key_dn[i] = 1'b1;
            step(2);
            chk("held early", 12'h0, 12'(ks.held));
            step(1);
            chk("press", {4'(1 << i), 4'(1 << i), 4'h0}, 12'(ks));
            step(1);
            chk("press end", {4'(1 << i), 8'h0}, 12'(ks));
            @(negedge clk) key_dn[i] = 1'b0;
            step(3);
            chk("release", {8'h0, 4'(1 << i)}, 12'(ks));
            step(1);
            chk("quiet", 12'h0, 12'(ks));
        end
    endtask
    // Bouncing switch moves settle through two flops
    task automatic t_switch;
        @(negedge clk) sw_up = 10'h2A5;
        step(1);
        chk("sw early", 12'h0, 12'(sw_lvl));
        step(1);
        chk("sw up", 12'h2A5, 12'(sw_lvl));
        @(negedge clk) sw_up = 10'h15A;
        step(2);
        chk("sw down", 12'h15A, 12'(sw_lvl));
    endtask
    // LED patterns and lamp test
    task automatic t_leds;
        @(negedge clk) led_v = 10'h155;
        step(1);
        chk("led", 12'h155, 12'(led_o));
        @(negedge clk) lamp = 1'b1;
        step(1);
        chk("lamp led", 12'h3FF, 12'(led_o));
        for (int d = 0; d < 6; d++) chk("lamp seg", 12'h0, 12'(seg[d]));
        @(negedge clk) lamp = 1'b0;
    endtask
    // Every hex value on every digit, then blanking
    task automatic t_digits;
        for (int v = 0; v < 16; v++) begin
            @(negedge clk);
            for (int d = 0; d < 6; d++) dig[d] = {1'b0, 4'(v + d)};
            step(1);
            for (int d = 0; d < 6; d++) chk("seg", {5'h00, ~GLY[(v + d) % 16]}, 12'(seg[d]));
        end
        @(negedge clk) dig[0].blank = 1'b1;
        dig[3].blank = 1'b1;
        step(1);
        chk("blank0", 12'h7F, 12'(seg[0]));
        chk("blank3", 12'h7F, 12'(seg[3]));
    endtask
    // Spare clocks seen, then one stops
    task automatic t_bclk;
        @(negedge clk) run = 3'h7;
        step(12);
        chk("alive", 12'h7, 12'(alive));
        @(negedge clk) run = 3'h5;
        step(ALIVE_N + 10);
        chk("one stopped", 12'h5, 12'(alive));
    endtask
    initial begin
        rst = 1'b1;
        lamp = 1'b0;
        key_dn = 4'h0;
        sw_up = 10'h0;
        led_v = 10'h0;
        run = 3'h0;
        dig = '0;
        step(4);
        chk("rst led", 12'h0, 12'(led_o));
        chk("rst seg", 12'h7F, 12'(seg[5]));
        chk("rst misc", 12'h0, 12'(ks) | 12'(sw_lvl) | 12'(alive));
        @(negedge clk) rst = 1'b0;
        t_keys();
        t_switch();
        t_leds();
        t_digits();
        t_bclk();
        report_and_stop();
    end
    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            report_and_stop();
        end
    end
endmodule
`default_nettype wire
